// ===== src/imk_map.vh
// Constants for the interrupt mask logic: addresses, fields, reset values.
// Included by every design file of the block; definitions only.
`ifndef IMK_MAP_VH
`define IMK_MAP_VH

`define IMK_PRIMARY_ADDR    8'ha8
`define IMK_EXTENDED_ADDR   8'he6
`define IMK_PRIMARY_RESET   8'h00
`define IMK_EXTENDED_RESET  8'h00
`define IMK_EXTENDED_WMASK  8'h3f

// Primary register fields
`define IMK_GATE_BIT        7
`define IMK_SPARE_BIT       6
`define IMK_T2_BIT          5
`define IMK_SER_BIT         4
`define IMK_T1_BIT          3
`define IMK_EXT1_BIT        2
`define IMK_T0_BIT          1
`define IMK_EXT0_BIT        0

// Extended register fields
`define IMK_CMPR_BIT        5
`define IMK_CMPF_BIT        4
`define IMK_PCA_BIT         3
`define IMK_CONV_BIT        2
`define IMK_WIN_BIT         1
`define IMK_TWB_BIT         0

// Request vector order
`define IMK_NSRC            12
`define IMK_REQ_EXT0        0
`define IMK_REQ_T0          1
`define IMK_REQ_EXT1        2
`define IMK_REQ_T1          3
`define IMK_REQ_SER         4
`define IMK_REQ_T2          5
`define IMK_REQ_TWB         6
`define IMK_REQ_WIN         7
`define IMK_REQ_CONV        8
`define IMK_REQ_PCA         9
`define IMK_REQ_CMPF        10
`define IMK_REQ_CMPR        11

`endif

// ===== src/imk_mask_reg.v
// One byte-wide mask register with whole-byte and single-bit writes.
// Assumes the core gives one-cycle strobes on clk; writable bits set by wmask.
`timescale 1ns/1ps
`default_nettype none
`include "imk_map.vh"

module imk_mask_reg #(
	parameter [7:0] reset_value = 8'h00,
	parameter [7:0] wmask       = 8'hff
) (
	input  wire       clk,
	input  wire       rstn,
	input  wire       ce,
	input  wire       wr_byte,
	input  wire       wr_bit,
	input  wire [2:0] bit_sel,
	input  wire       bit_val,
	input  wire [7:0] wdata,
	output reg  [7:0] value
);

	reg [7:0] next_value;

	// ----------------------------------------
	// Next value
	// ----------------------------------------
	always @* begin
		next_value = value;
		if (wr_byte) begin
			next_value = wdata & wmask;
		end else if (wr_bit) begin
			next_value[bit_sel] = bit_val & wmask[bit_sel];
		end
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			value <= reset_value;
		end else if (ce) begin
			value <= next_value;
		end
	end

endmodule // imk_mask_reg

`default_nettype wire

// ===== src/imk_req_gate.v
// Forwards each source flag to the core only under its mask and the gate.
// Assumes flags already come from the core clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "imk_map.vh"

module imk_req_gate (
	input  wire                  gate,
	input  wire [`IMK_NSRC-1:0]  flags,
	input  wire [`IMK_NSRC-1:0]  masks,
	output wire [`IMK_NSRC-1:0]  req
);

	genvar i;
	generate
		for (i = 0; i < `IMK_NSRC; i = i + 1) begin : g_src
			assign req[i] = flags[i] & masks[i] & gate;
		end
	endgenerate

endmodule // imk_req_gate

`default_nettype wire

// ===== src/imk_top.v
// Interrupt mask logic: primary and extended enable registers on the
// special-function bus, and the per-source request gating to the core.
// Assumes a synchronous special-function bus on clk and flags on clk.
//
// Summary of operation
// - Primary bit 7 gates all requests; zero blocks every source.
// - Primary bit 6 is a spare software flag with no effect.
// - Primary bit 5 passes timer 2 low or high overflow requests.
// - Primary bit 4 masks the serial port request.
// - Primary bit 3 masks the timer 1 overflow request.
// - Primary bit 2 masks the second external input request.
// - Primary bit 1 masks the timer 0 overflow request.
// - Primary bit 0 masks the first external input request.
// - Primary register at 0xa8, bit-addressable, resets to zero.
// - Extended bit 5 masks the comparator rising-edge request.
// - Extended bit 4 masks the comparator falling-edge request.
// - Extended bit 3 masks all counter array requests.
// - Extended bit 2 masks the conversion-done request.
// - Extended bit 1 masks the window-compare request.
// - Extended bit 0 masks all two-wire bus requests.
// - Window-compare flag stays readable while its mask is clear.
`timescale 1ns/1ps
`default_nettype none
`include "imk_map.vh"

module imk_top (
	input  wire        clk,
	input  wire        rstn,
	input  wire        ce,
	input  wire [7:0]  sfr_addr,
	input  wire        sfr_wr,
	input  wire [7:0]  sfr_wdata,
	input  wire        sfr_rd,
	output reg  [7:0]  sfr_rdata,
	output wire        sfr_hit,
	input  wire        sfr_bit_wr,
	input  wire [2:0]  sfr_bit_sel,
	input  wire        sfr_bit_val,
	input  wire        timer0_overflow_flag,
	input  wire        timer1_overflow_flag,
	input  wire        timer2_low_overflow_flag,
	input  wire        timer2_high_overflow_flag,
	input  wire        serial_port_flag,
	input  wire        first_external_request,
	input  wire        second_external_request,
	input  wire        comparator_rising_flag,
	input  wire        comparator_falling_flag,
	input  wire        counter_array_flag,
	input  wire        conversion_done_flag,
	input  wire        window_compare_flag,
	input  wire        two_wire_bus_flag,
	output wire        window_compare_status,
	output wire        spare_user_flag,
	output wire [11:0] irq_req,
	output wire        irq_any
);

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	function is_addr;
		input [7:0] a;
		input [7:0] target;
		begin
			is_addr = (a == target);
		end
	endfunction

	wire hit_pri = is_addr(sfr_addr, `IMK_PRIMARY_ADDR);
	wire hit_ext = is_addr(sfr_addr, `IMK_EXTENDED_ADDR);
	assign sfr_hit = hit_pri | hit_ext;

	wire [7:0] primary_irq_mask_reg;
	wire [7:0] extended_irq_mask_reg;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Bit writes only reach the primary one; the extended one is not bit-addressable
	imk_mask_reg #(
		.reset_value (`IMK_PRIMARY_RESET),
		.wmask       (8'hff)
	) u_primary (
		.clk     (clk),
		.rstn    (rstn),
		.ce      (ce),
		.wr_byte (sfr_wr & hit_pri),
		.wr_bit  (sfr_bit_wr & hit_pri),
		.bit_sel (sfr_bit_sel),
		.bit_val (sfr_bit_val),
		.wdata   (sfr_wdata),
		.value   (primary_irq_mask_reg)
	);

	imk_mask_reg #(
		.reset_value (`IMK_EXTENDED_RESET),
		.wmask       (`IMK_EXTENDED_WMASK)
	) u_extended (
		.clk     (clk),
		.rstn    (rstn),
		.ce      (ce),
		.wr_byte (sfr_wr & hit_ext),
		.wr_bit  (1'b0),
		.bit_sel (3'h0),
		.bit_val (1'b0),
		.wdata   (sfr_wdata),
		.value   (extended_irq_mask_reg)
	);

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// Registered so data comes from flops; unmapped reads return zero
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sfr_rdata <= 8'h00;
		end else if (ce && sfr_rd) begin
			if (hit_pri) begin
				sfr_rdata <= primary_irq_mask_reg;
			end else if (hit_ext) begin
				sfr_rdata <= extended_irq_mask_reg;
			end else begin
				sfr_rdata <= 8'h00;
			end
		end
	end

	// ----------------------------------------
	// Fields
	// ----------------------------------------
	wire global_irq_gate         = primary_irq_mask_reg[`IMK_GATE_BIT];
	wire timer2_irq_mask         = primary_irq_mask_reg[`IMK_T2_BIT];
	wire serial_port_irq_mask    = primary_irq_mask_reg[`IMK_SER_BIT];
	wire timer1_irq_mask         = primary_irq_mask_reg[`IMK_T1_BIT];
	wire ext_input1_irq_mask     = primary_irq_mask_reg[`IMK_EXT1_BIT];
	wire timer0_irq_mask         = primary_irq_mask_reg[`IMK_T0_BIT];
	wire ext_input0_irq_mask     = primary_irq_mask_reg[`IMK_EXT0_BIT];
	wire comparator_rising_mask  = extended_irq_mask_reg[`IMK_CMPR_BIT];
	wire comparator_falling_mask = extended_irq_mask_reg[`IMK_CMPF_BIT];
	wire counter_array_irq_mask  = extended_irq_mask_reg[`IMK_PCA_BIT];
	wire conversion_done_mask    = extended_irq_mask_reg[`IMK_CONV_BIT];
	wire window_compare_mask     = extended_irq_mask_reg[`IMK_WIN_BIT];
	wire two_wire_bus_irq_mask   = extended_irq_mask_reg[`IMK_TWB_BIT];

	// Software-only flag, wired to nothing in the gating
	assign spare_user_flag = primary_irq_mask_reg[`IMK_SPARE_BIT];

	// Polling path independent of mask
	assign window_compare_status = window_compare_flag;

	// ----------------------------------------
	// Request gating
	// ----------------------------------------
	wire [`IMK_NSRC-1:0] flags;
	wire [`IMK_NSRC-1:0] masks;

	assign flags[`IMK_REQ_EXT0] = first_external_request;
	assign flags[`IMK_REQ_T0]   = timer0_overflow_flag;
	assign flags[`IMK_REQ_EXT1] = second_external_request;
	assign flags[`IMK_REQ_T1]   = timer1_overflow_flag;
	assign flags[`IMK_REQ_SER]  = serial_port_flag;
	assign flags[`IMK_REQ_T2]   = timer2_low_overflow_flag
		| timer2_high_overflow_flag;
	assign flags[`IMK_REQ_TWB]  = two_wire_bus_flag;
	assign flags[`IMK_REQ_WIN]  = window_compare_flag;
	assign flags[`IMK_REQ_CONV] = conversion_done_flag;
	assign flags[`IMK_REQ_PCA]  = counter_array_flag;
	assign flags[`IMK_REQ_CMPF] = comparator_falling_flag;
	assign flags[`IMK_REQ_CMPR] = comparator_rising_flag;

	assign masks[`IMK_REQ_EXT0] = ext_input0_irq_mask;
	assign masks[`IMK_REQ_T0]   = timer0_irq_mask;
	assign masks[`IMK_REQ_EXT1] = ext_input1_irq_mask;
	assign masks[`IMK_REQ_T1]   = timer1_irq_mask;
	assign masks[`IMK_REQ_SER]  = serial_port_irq_mask;
	assign masks[`IMK_REQ_T2]   = timer2_irq_mask;
	assign masks[`IMK_REQ_TWB]  = two_wire_bus_irq_mask;
	assign masks[`IMK_REQ_WIN]  = window_compare_mask;
	assign masks[`IMK_REQ_CONV] = conversion_done_mask;
	assign masks[`IMK_REQ_PCA]  = counter_array_irq_mask;
	assign masks[`IMK_REQ_CMPF] = comparator_falling_mask;
	assign masks[`IMK_REQ_CMPR] = comparator_rising_mask;

	// Combinational from register and flags: a mask written at edge N acts after N
	imk_req_gate u_gate (
		.gate  (global_irq_gate),
		.flags (flags),
		.masks (masks),
		.req   (irq_req)
	);

	assign irq_any = |irq_req;

endmodule // imk_top

`default_nettype wire

// ===== test/imk_top_monitor.sv
// Checker for the mask logic, bound to imk_top by the bench top file.
// Sees only top-level ports; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module imk_top_monitor (
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        ce,
	input wire logic [7:0]  sfr_addr,
	input wire logic        sfr_wr,
	input wire logic [7:0]  sfr_wdata,
	input wire logic        sfr_rd,
	input wire logic [7:0]  sfr_rdata,
	input wire logic        sfr_hit,
	input wire logic        sfr_bit_wr,
	input wire logic [2:0]  sfr_bit_sel,
	input wire logic        sfr_bit_val,
	input wire logic        first_external_request,
	input wire logic        timer2_low_overflow_flag,
	input wire logic        timer2_high_overflow_flag,
	input wire logic        window_compare_flag,
	input wire logic        window_compare_status,
	input wire logic        spare_user_flag,
	input wire logic [11:0] irq_req,
	input wire logic        irq_any
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	wire pw;
	assign pw = ce && sfr_wr && sfr_addr == 8'ha8;
	a_gate_blocks: assert property (pw && !sfr_wdata[7] |=> irq_req == 12'h000)
		else $error("request passed while gate clear");
	a_ext0_pass: assert property (pw && sfr_wdata[7] && sfr_wdata[0]
		|=> irq_req[0] == first_external_request) else $error("ext0 request wrong");
	a_t2_either: assert property (pw && sfr_wdata[7] && sfr_wdata[5]
		|=> irq_req[5] == (timer2_low_overflow_flag | timer2_high_overflow_flag))
		else $error("timer2 request wrong");
	a_spare_byte: assert property (pw |=> spare_user_flag == $past(sfr_wdata[6]))
		else $error("spare flag not written");
	a_spare_bit: assert property (ce && sfr_bit_wr && !sfr_wr && sfr_addr == 8'ha8
		&& sfr_bit_sel == 3'h6 |=> spare_user_flag == $past(sfr_bit_val))
		else $error("bit write missed");
	a_unmapped_read: assert property (ce && sfr_rd && sfr_addr != 8'ha8
		&& sfr_addr != 8'he6 |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
	a_ext_top_zero: assert property (ce && sfr_rd && sfr_addr == 8'he6
		|=> sfr_rdata[7:6] == 2'h0) else $error("unused bits read set");
	a_any_or: assert property (irq_any == |irq_req)
		else $error("summary request wrong");
	a_window_poll: assert property (window_compare_status == window_compare_flag)
		else $error("window status lost");
	a_hit_decode: assert property (sfr_hit ==
		(sfr_addr == 8'ha8 || sfr_addr == 8'he6)) else $error("address decode wrong");
	a_ce_freeze: assert property (!ce
		|=> $stable(sfr_rdata) && $stable(spare_user_flag))
		else $error("state moved while clock enable low");
	c_ce_hold: cover property (!ce && sfr_wr);
	c_gate_on: cover property (pw && sfr_wdata[7]);
	c_bit_wr: cover property (ce && sfr_bit_wr);
	c_any: cover property ($rose(irq_any));
endmodule // imk_top_monitor
`default_nettype wire

// ===== test/imk_flag_src.sv
// Peripheral flag sources seen by the mask logic.
// Flags are registered, so they change just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module imk_flag_src (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic [12:0] ev,
	output var  logic [12:0] flags
);
	always @(posedge clk or negedge rstn) begin
		if (!rstn)
			flags <= 13'h0000;
		else
			flags <= ev;
	end
endmodule // imk_flag_src
`default_nettype wire

// ===== test/imk_top_tb.sv
// Self-checking bench for the mask logic over its special-function bus.
// Flags come from imk_flag_src; bit 12 is the timer 2 high flag.
`timescale 1ns/1ps
`default_nettype none
module imk_top_tb;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        ce = 1'b1;
	logic [7:0]  sfr_addr = 8'h00;
	logic        sfr_wr = 1'b0;
	logic [7:0]  sfr_wdata = 8'h00;
	logic        sfr_rd = 1'b0;
	logic        sfr_bit_wr = 1'b0;
	logic [2:0]  sfr_bit_sel = 3'h0;
	logic        sfr_bit_val = 1'b0;
	logic [12:0] ev = 13'h0000;
	wire  [12:0] fl;
	wire  [7:0]  sfr_rdata;
	wire  [11:0] irq_req;
	wire         win_st;
	wire         spare;
	wire         irq_any;
	wire         hit;
	int          fails = 0;
	int          comparisons = 0;
	int          b;
	imk_flag_src src (.clk(clk), .rstn(rstn), .ev(ev), .flags(fl));
	imk_top uut (.clk(clk), .rstn(rstn), .ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_hit(hit),
		.sfr_bit_wr(sfr_bit_wr), .sfr_bit_sel(sfr_bit_sel), .sfr_bit_val(sfr_bit_val),
		.first_external_request(fl[0]), .timer0_overflow_flag(fl[1]),
		.second_external_request(fl[2]), .timer1_overflow_flag(fl[3]),
		.serial_port_flag(fl[4]), .timer2_low_overflow_flag(fl[5]),
		.two_wire_bus_flag(fl[6]), .window_compare_flag(fl[7]),
		.conversion_done_flag(fl[8]), .counter_array_flag(fl[9]),
		.comparator_falling_flag(fl[10]), .comparator_rising_flag(fl[11]),
		.timer2_high_overflow_flag(fl[12]), .window_compare_status(win_st),
		.spare_user_flag(spare), .irq_req(irq_req), .irq_any(irq_any));
	initial forever #25 clk = ~clk;
	task automatic chk(input logic [11:0] s, input logic [11:0] e);
		comparisons++;
		if (s !== e) begin
			fails++;
			$display("MISMATCH %0t seen %h want %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge clk);
		sfr_wr <= 1'b0;
	endtask
	task automatic bw(input logic [2:0] s, input logic v);
		@(posedge clk);
		sfr_addr <= 8'ha8;
		sfr_bit_sel <= s;
		sfr_bit_val <= v;
		sfr_bit_wr <= 1'b1;
		@(posedge clk);
		sfr_bit_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge clk);
		sfr_rd <= 1'b0;
		#1 chk({4'h0, sfr_rdata}, {4'h0, e});
		chk({11'h000, hit}, {11'h000, a == 8'ha8 || a == 8'he6});
	endtask
	task automatic req(input logic [11:0] e);
		@(posedge clk);
		#1 chk(irq_req, e);
		chk({11'h000, irq_any}, {11'h000, |e});
	endtask
	task automatic test_done;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rd(8'ha8, 8'h00);
		rd(8'he6, 8'h00);
		rd(8'h99, 8'h00);
		wr(8'he6, 8'hff);
		rd(8'he6, 8'h3f);
		wr(8'he6, 8'h00);
		ev <= 13'h1fff;
		for (b = 0; b < 7; b++) begin
			wr(8'ha8, 8'h80 | (8'h01 << b));
			req(b < 6 ? 12'h001 << b : 12'h000);
		end
		wr(8'ha8, 8'h80);
		for (b = 0; b < 6; b++) begin
			wr(8'he6, 8'h01 << b);
			req(12'h040 << b);
		end
		wr(8'he6, 8'h3f);
		wr(8'ha8, 8'h7f);
		req(12'h000);
		chk({11'h000, spare}, 12'h001);
		bw(3'h7, 1'b1);
		req(12'hfff);
		bw(3'h6, 1'b0);
		req(12'hfff);
		chk({11'h000, spare}, 12'h000);
		ev <= 13'h1000;
		req(12'h020);
		ev <= 13'h0020;
		req(12'h020);
		ev <= 13'h0080;
		wr(8'he6, 8'h00);
		req(12'h000);
		chk({11'h000, win_st}, 12'h001);
		wr(8'h99, 8'h00);
		rd(8'ha8, 8'hbf);
		ce <= 1'b0;
		wr(8'ha8, 8'h00);
		rd(8'he6, 8'hbf);
		ce <= 1'b1;
		rd(8'ha8, 8'hbf);
		wr(8'he6, 8'h3f);
		rd(8'he6, 8'h3f);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rd(8'ha8, 8'h00);
		rd(8'he6, 8'h00);
		req(12'h000);
		test_done;
	end
	initial begin
		#20000;
		fails++;
		test_done;
	end
endmodule // imk_top_tb
bind imk_top imk_top_monitor mon (
	.clk                       (clk),
	.rstn                      (rstn),
	.ce                        (ce),
	.sfr_addr                  (sfr_addr),
	.sfr_wr                    (sfr_wr),
	.sfr_wdata                 (sfr_wdata),
	.sfr_rd                    (sfr_rd),
	.sfr_rdata                 (sfr_rdata),
	.sfr_hit                   (sfr_hit),
	.sfr_bit_wr                (sfr_bit_wr),
	.sfr_bit_sel               (sfr_bit_sel),
	.sfr_bit_val               (sfr_bit_val),
	.first_external_request    (first_external_request),
	.timer2_low_overflow_flag  (timer2_low_overflow_flag),
	.timer2_high_overflow_flag (timer2_high_overflow_flag),
	.window_compare_flag       (window_compare_flag),
	.window_compare_status     (window_compare_status),
	.spare_user_flag           (spare_user_flag),
	.irq_req                   (irq_req),
	.irq_any                   (irq_any)
);
`default_nettype wire
